// ### logic/fanout_control_pins_los.sv
// Control-pin logic: output gating, source select, missing-reference flag
`timescale 1ns/1ps
`default_nettype none
module fanout_control_pins_los (
  input  wire logic                                 clk_i,
  input  wire logic                                 reset_n_i,
  // Reference clocks sampled as levels
  input  wire logic                                 ref0_i,
  input  wire logic                                 ref1_i,
  input  wire logic                                 src_sel_i,
  // Gating pins, active high, and their configured scope
  // Each pin owns a 2-bit scope slice and a 4-bit target slice
  input  wire logic [fanout_ctrl_pkg::NUM_GATE-1:0] out_off_i,
  input  wire logic [2*fanout_ctrl_pkg::NUM_GATE-1:0] gate_scope_i,
  input  wire logic [4*fanout_ctrl_pkg::NUM_GATE-1:0] gate_target_i,
  input  wire logic                                 flag_pol_i,
  // Buffered clock and per-output enables
  output logic                                      clk_sel_o,
  output logic [fanout_ctrl_pkg::NUM_OUT-1:0]       out_en_o,
  output logic [fanout_ctrl_pkg::NUM_OUT-1:0]       out_p_o,
  output logic [fanout_ctrl_pkg::NUM_OUT-1:0]       out_n_o,
  output logic                                      ref_missing_flag_o
);
  // Output count, used to size the local arrays
  localparam int unsigned N = fanout_ctrl_pkg::NUM_OUT;

  logic              pol;            // Polarity caught after reset
  logic              pol_taken;      // Polarity latch done
  logic              sel_q;          // Registered source choice
  logic              ref_q;          // Selected reference, registered
  logic              ref_prev;       // Previous sample for edge detect
  logic              ref_edge;       // Rising edge of selected reference
  logic              missing;        // Monitor verdict
  logic [N-1:0]      want_on;        // Enable request per output
  // Per-output gating state and its cycle counter
  logic [7:0]        cnt [N];        // Gating timers per output
  fanout_ctrl_pkg::gate_state_t st [N];

  // Outputs covered by one gating pin's scope
  function automatic logic [N-1:0] scope_mask(input logic [1:0] scope,
                                              input logic [3:0] tgt);
    logic [N-1:0] m;
    m = '0;
    unique case (scope)
      fanout_ctrl_pkg::SCOPE_SINGLE: begin
        // Index past the last output selects nothing
        if (tgt < 4'(N)) begin
          m[tgt] = 1'b1;
        end
      end
      fanout_ctrl_pkg::SCOPE_BANK: begin
        // Bank number is the low target bit only
        for (int b = 0; b < N; b++) begin
          if (b / fanout_ctrl_pkg::BANK_SIZE == int'(tgt[0])) begin
            m[b] = 1'b1;
          end
        end
      end
      fanout_ctrl_pkg::SCOPE_GLOBAL: m = '1;
      default: m = '0;  // Unassigned pin gates nothing
    endcase
    return m;
  endfunction

  // Output drives while on and through the stop tail
  function automatic logic is_driving(
      input fanout_ctrl_pkg::gate_state_t s);
    return (s == fanout_ctrl_pkg::GATE_ON) ||
           (s == fanout_ctrl_pkg::GATE_STOP);
  endfunction

  // Any pin held high disables its scope; low enables
  // Scopes may overlap; one high pin is enough to gate
  always_comb begin
    want_on = '1;
    for (int g = 0; g < fanout_ctrl_pkg::NUM_GATE; g++) begin
      // A high pin clears every output in its scope
      if (out_off_i[g]) begin
        want_on = want_on & ~scope_mask(gate_scope_i[2*g +: 2],
                                        gate_target_i[4*g +: 4]);
      end
    end
  end

  // Polarity is a configuration level, caught once after release
  // Later changes on the pin wait for the next reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pol       <= fanout_ctrl_pkg::POL_HIGH;
      pol_taken <= 1'b0;
    end else if (!pol_taken) begin
      pol       <= flag_pol_i;
      pol_taken <= 1'b1;
    end
  end

  // Source choice; switch is immediate, so no glitch protection
  // One register feeds both the mux and the monitor restart
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= src_sel_i;
    end
  end

  // Registered selected reference is the buffered clock
  // Sampling caps usable references at under half of clk
  // Both flops start low so no false edge follows reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_q    <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_q    <= sel_q ? ref1_i : ref0_i;
      ref_prev <= ref_q;
    end
  end

  // One-cycle pulse on each rising edge of the buffered clock
  assign ref_edge = ref_q & ~ref_prev;

  // Monitor restarts on source change so it judges the new one
  // Restart fires in the cycle the pin differs from its register
  ref_monitor u_mon (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ref_edge_i(ref_edge),
    .restart_i (sel_q != src_sel_i),
    .missing_o (missing)
  );

  // Flag follows chosen polarity; controller polls it
  // A flop, so the polled pin never glitches
  // Resets high; reads as missing until the first window verdict once pol is caught
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_missing_flag_o <= 1'b1;
    end else if (pol == fanout_ctrl_pkg::POL_HIGH) begin
      ref_missing_flag_o <= missing;
    end else begin
      ref_missing_flag_o <= ~missing;
    end
  end

  // Gating state per output, stepped on buffered-clock edges
  // Moves only on reference edges, so out_n_o pulses stay whole, but out_p_o high pulses are cut at start and stop;
  // the price is that all timing is counted in reference cycles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < N; i++) begin
        st[i]  <= fanout_ctrl_pkg::GATE_OFF;
        cnt[i] <= '0;
      end
    end else if (ref_edge) begin
      for (int i = 0; i < N; i++) begin
        unique case (st[i])
          fanout_ctrl_pkg::GATE_OFF: begin
            // Held low until an enable request arrives
            cnt[i] <= '0;
            if (want_on[i]) begin
              st[i] <= fanout_ctrl_pkg::GATE_WAKE;
            end
          end
          fanout_ctrl_pkg::GATE_WAKE: begin
            // Settle count, well under the 20 us bound
            // A dropped request during wake returns to off
            if (!want_on[i]) begin
              st[i] <= fanout_ctrl_pkg::GATE_OFF;
            end else if (cnt[i] ==
                8'(fanout_ctrl_pkg::ON_CYC - 1)) begin
              st[i]  <= fanout_ctrl_pkg::GATE_ON;
              cnt[i] <= '0;
            end else begin
              cnt[i] <= cnt[i] + 8'h01;
            end
          end
          fanout_ctrl_pkg::GATE_ON: begin
            // Full clock; a disable request starts the stop tail
            cnt[i] <= '0;
            if (!want_on[i]) begin
              st[i] <= fanout_ctrl_pkg::GATE_STOP;
            end
          end
          fanout_ctrl_pkg::GATE_STOP: begin
            // Keep driving a few cycles, then stop
            // The entry edge counts as the first of three
            if (cnt[i] == 8'(fanout_ctrl_pkg::OFF_CYC - 2)) begin
              st[i]  <= fanout_ctrl_pkg::GATE_OFF;
              cnt[i] <= '0;
            end else begin
              cnt[i] <= cnt[i] + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // Driven outputs: pair halves share one enable, off holds low
  // Enable and clock halves share one register stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_en_o  <= '0;
      out_p_o   <= '0;
      out_n_o   <= '0;
      clk_sel_o <= 1'b0;
    end else begin
      clk_sel_o <= ref_q;
      for (int i = 0; i < N; i++) begin
        out_en_o[i] <= is_driving(st[i]);
        if (is_driving(st[i])) begin
          out_p_o[i] <= ref_q;
          out_n_o[i] <= ~ref_q;
        end else begin
          out_p_o[i] <= 1'b0;
          out_n_o[i] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/fanout_ctrl_pkg.sv
// Constants and types for the fanout buffer control-pin logic
package fanout_ctrl_pkg;
  localparam int unsigned NUM_OUT       = 10;  // Differential outputs
  localparam int unsigned NUM_BANK      = 2;   // Output banks
  localparam int unsigned NUM_GATE      = 4;   // Gating pins
  localparam int unsigned BANK_SIZE     = 5;   // Outputs per bank
  // Scope codes for a gating pin
  localparam logic [1:0]  SCOPE_SINGLE  = 2'h0;
  localparam logic [1:0]  SCOPE_BANK    = 2'h1;
  localparam logic [1:0]  SCOPE_GLOBAL  = 2'h2;
  // Gating timing in buffered cycles
  localparam int unsigned OFF_MIN_CYC   = 2;
  localparam int unsigned OFF_MAX_CYC   = 6;
  localparam int unsigned OFF_CYC       = 3;   // Chosen inside 2..6
  // Enable settle time and its count at 50 MHz
  localparam int unsigned ON_TIME_NS    = 20000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ON_MAX_CYC    = ON_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned ON_CYC        = 16;  // Well below the ceiling
  // Minimum reference frequency and monitor window
  localparam int unsigned FIN_MIN_MHZ   = 10;
  localparam int unsigned CLK_MHZ       = 1000 / CLK_PERIOD_NS;
  localparam int unsigned WIN_CYC       = 50;  // One microsecond window
  // Rising edges needed per window at the minimum frequency
  localparam int unsigned EDGE_MIN      = FIN_MIN_MHZ * WIN_CYC / CLK_MHZ;
  localparam int unsigned CNT_W         = 8;
  // Flag polarity codes
  localparam logic        POL_HIGH      = 1'b1;
  localparam logic        POL_LOW       = 1'b0;
  // Per-output gating state
  typedef enum logic [1:0] {
    GATE_OFF,
    GATE_WAKE,
    GATE_ON,
    GATE_STOP
  } gate_state_t;
endpackage

// ### logic/ref_monitor.sv
// Reference activity monitor feeding the missing-reference flag
`timescale 1ns/1ps
`default_nettype none
module ref_monitor (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ref_edge_i,    // One-cycle pulse per reference edge
  input  wire logic restart_i,     // Selection changed: start over
  output logic      missing_o      // High while reference is too slow
);
  logic [fanout_ctrl_pkg::CNT_W-1:0] win_cnt;   // Window position
  logic [fanout_ctrl_pkg::CNT_W-1:0] edge_cnt;  // Edges seen in window

  // Window timer; restart aligns to the new source
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt <= '0;
    end else if (restart_i ||
        win_cnt == fanout_ctrl_pkg::CNT_W'(fanout_ctrl_pkg::WIN_CYC - 1)) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + fanout_ctrl_pkg::CNT_W'(1);
    end
  end

  // Edge tally, saturating so a fast clock cannot wrap
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_cnt <= '0;
    end else if (restart_i ||
        win_cnt == fanout_ctrl_pkg::CNT_W'(fanout_ctrl_pkg::WIN_CYC - 1)) begin
      edge_cnt <= '0;
    end else if (ref_edge_i && edge_cnt != '1) begin
      edge_cnt <= edge_cnt + fanout_ctrl_pkg::CNT_W'(1);
    end
  end

  // Verdict at window end; starts as missing until proven present
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      missing_o <= 1'b1;
    end else if (win_cnt ==
        fanout_ctrl_pkg::CNT_W'(fanout_ctrl_pkg::WIN_CYC - 1)) begin
      missing_o <= (edge_cnt <
        fanout_ctrl_pkg::CNT_W'(fanout_ctrl_pkg::EDGE_MIN));
    end
  end
endmodule
`default_nettype wire

// ### testbench/fanout_checker_properties.sv
// Checker for the fanout control-pin block
`timescale 1ns/1ps
`default_nettype none
module fanout_checker (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        ref0_i,
  input wire logic        ref1_i,
  input wire logic        src_sel_i,
  input wire logic [3:0]  out_off_i,
  input wire logic [7:0]  gate_scope_i,
  input wire logic [15:0] gate_target_i,
  input wire logic        flag_pol_i,
  input wire logic        clk_sel_o,
  input wire logic [9:0]  out_en_o,
  input wire logic [9:0]  out_p_o,
  input wire logic [9:0]  out_n_o,
  input wire logic        ref_missing_flag_o
);
  logic       glob_off;  // A global pin is high
  logic       sel_ref;   // Reference the select asks for
  logic       prev_sel;  // Last buffered clock level
  logic [3:0] off_e;     // Buffered edges while gated
  logic [4:0] on_e;      // Buffered edges with all pins low
  logic [7:0] gap;       // Cycles since last buffered edge
  logic [7:0] fast;      // Cycles of a steady fast reference
  logic [2:0] age;       // Cycles since reset release
  wire        edge_s = clk_sel_o & ~prev_sel;
  assign sel_ref = src_sel_i ? ref1_i : ref0_i;
  // Scope code 2 on a high pin gates everything
  always_comb begin
    glob_off = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (gate_scope_i[2*k+:2] == 2'h2 && out_off_i[k])
        glob_off = 1'b1;
    end
  end
  // Edge and gap counters; saturate so they never wrap
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_sel <= 1'b0;
      off_e <= 4'h0;
      on_e <= 5'h00;
      gap <= 8'h00;
      fast <= 8'h00;
      age <= 3'h0;
    end else begin
      prev_sel <= clk_sel_o;
      age <= (age == 3'h7) ? age : age + 3'h1;
      if (!glob_off)
        off_e <= 4'h0;
      else if (edge_s && off_e != 4'hF)
        off_e <= off_e + 4'h1;
      if (out_off_i != 4'h0)
        on_e <= 5'h00;
      else if (edge_s && on_e != 5'h18)
        on_e <= on_e + 5'h01;
      // Select change restarts the monitor, so restart here too
      if ($changed(src_sel_i) || edge_s)
        gap <= 8'h00;
      else if (gap != 8'hFF)
        gap <= gap + 8'h01;
      if ($changed(src_sel_i) || gap > 8'h04)
        fast <= 8'h00;
      else if (fast != 8'hFF)
        fast <= fast + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  AST_PAIR_OFF: assert property (
    ((out_p_o | out_n_o) & ~out_en_o) == 10'h000)
    else $error("disabled pair not static");
  AST_PAIR_COMP: assert property (
    (out_p_o ^ out_n_o) == out_en_o)
    else $error("pair halves not complementary");
  AST_OFF_EARLY: assert property (
    glob_off && $past(glob_off) && off_e < 4'h2 && $past(&out_en_o)
    |-> &out_en_o)
    else $error("outputs stopped too early");
  AST_OFF_LATE: assert property (
    off_e >= 4'h7 |-> out_en_o == 10'h000)
    else $error("outputs still driven after gating");
  AST_ON_BOUND: assert property (
    on_e == 5'h18 |-> out_en_o == 10'h3FF)
    else $error("outputs not back after enable");
  AST_FLAG_MISS: assert property (
    gap >= 8'h78 |-> ref_missing_flag_o == flag_pol_i)
    else $error("missing reference not flagged");
  AST_FLAG_OK: assert property (
    fast >= 8'h96 |-> ref_missing_flag_o == !flag_pol_i)
    else $error("present reference flagged");
  AST_SEL_ROUTE: assert property (
    age == 3'h7 && $past(src_sel_i, 2) == $past(src_sel_i, 3)
    |-> clk_sel_o == $past(sel_ref, 2))
    else $error("wrong reference routed");
  COV_OFF: cover property (off_e == 4'h7);
  COV_ON: cover property (on_e == 5'h18);
  COV_FLAG: cover property ($rose(ref_missing_flag_o));
endmodule
bind fanout_control_pins_los fanout_checker i_chk (
  .clk_i, .reset_n_i, .ref0_i, .ref1_i, .src_sel_i, .out_off_i,
  .gate_scope_i, .gate_target_i, .flag_pol_i, .clk_sel_o, .out_en_o,
  .out_p_o, .out_n_o, .ref_missing_flag_o
);
`default_nettype wire

// ### testbench/ref_source.sv
// Reference clock source standing in for a far-side oscillator
`timescale 1ns/1ps
`default_nettype none
module ref_source (
  input  wire logic       clk_i,
  input  wire logic [3:0] half_i,  // Half period in clocks, 0 stops
  output logic            ref_o
);
  logic [3:0] cnt;  // Clocks into the current half period
  initial begin
    ref_o = 1'b0;
    cnt = 4'h0;
  end
  // A stopped source rests low, as a dead oscillator would
  always @(posedge clk_i) begin
    if (half_i == 4'h0) begin
      ref_o <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt + 4'h1 >= half_i) begin
      ref_o <= ~ref_o;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/fanout_control_pins_los_tb.sv
// Self-checking bench for the control-pin block
`timescale 1ns/1ps
`default_nettype none
module fanout_control_pins_los_tb;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       src_sel_i = 1'b0;
  logic [3:0] out_off_i = 4'h0;
  logic       flag_pol_i = 1'b1;
  logic [3:0] half0 = 4'h2;  // 12.5 MHz, above the floor
  wire logic  ref0;
  wire logic  ref1;
  logic       clk_sel_o;
  logic [9:0] out_en_o;
  logic [9:0] out_p_o;
  logic [9:0] out_n_o;
  logic       flag_o;
  int         fail_count = 0;
  int         total_checks = 0;
  // Pin k alone high: expected enables per scope code
  logic [9:0] exp_en [4] = '{10'h3F7, 10'h01F, 10'h000, 10'h3FF};
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  ref_source i_ref0 (.clk_i(clk_i), .half_i(half0), .ref_o(ref0));
  ref_source i_ref1 (.clk_i(clk_i), .half_i(4'h0), .ref_o(ref1));
  // Pin 0 single output 3, pin 1 bank 1, pin 2 all, pin 3 unused
  fanout_control_pins_los i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ref0_i(ref0), .ref1_i(ref1),
    .src_sel_i(src_sel_i), .out_off_i(out_off_i),
    .gate_scope_i(8'hE4), .gate_target_i(16'h0013),
    .flag_pol_i(flag_pol_i), .clk_sel_o(clk_sel_o), .out_en_o(out_en_o),
    .out_p_o(out_p_o), .out_n_o(out_n_o), .ref_missing_flag_o(flag_o)
  );
  task automatic check(input string name, input logic [9:0] exp,
                       input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_flag(input string name, input logic exp,
                            input logic got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Controller sets pins at an edge, then waits settled
  task automatic drive(input logic [3:0] off, input logic sel,
                       input logic [3:0] h0, input int cyc);
    @(posedge clk_i);
    out_off_i <= off;
    src_sel_i <= sel;
    half0 <= h0;
    repeat (cyc) @(posedge clk_i);
    #1;
  endtask
  task automatic restart(input logic pol);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    flag_pol_i <= pol;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask
  initial begin
    restart(1'b1);
    for (int k = 0; k < 4; k++) begin
      drive(4'h0, 1'b0, 4'h2, 200);
      check("enable", 10'h3FF, out_en_o);
      drive(4'h1 << k, 1'b0, 4'h2, 4);
      check("early", 10'h3FF, out_en_o);
      drive(4'h1 << k, 1'b0, 4'h2, 40);
      check("scope", exp_en[k], out_en_o);
      check("pair", 10'h000, (out_p_o | out_n_o) & ~out_en_o);
    end
    drive(4'h0, 1'b0, 4'h2, 200);
    check_flag("flag on", 1'b0, flag_o);
    drive(4'h0, 1'b1, 4'h2, 200);
    check_flag("flag ref1", 1'b1, flag_o);
    check_flag("route a", 1'b0, clk_sel_o);
    repeat (2) @(posedge clk_i);
    #1;
    check_flag("route b", 1'b0, clk_sel_o);
    drive(4'h0, 1'b0, 4'h2, 200);
    check_flag("flag ref0", 1'b0, flag_o);
    drive(4'h0, 1'b0, 4'h4, 300);
    check_flag("flag slow", 1'b1, flag_o);
    restart(1'b0);
    drive(4'h0, 1'b0, 4'h2, 200);
    check_flag("low on", 1'b1, flag_o);
    drive(4'h0, 1'b0, 4'h0, 300);
    check_flag("low off", 1'b0, flag_o);
    give_verdict();
  end
  // Tests take about 2400 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
